// ==== dfl_pkg.sv ====
/*
  Shared constants and carrier types for the channel diagnosis flag block.
  Assumes one serial frame of eight bits, most significant bit first.
*/
`default_nettype none
package dfl_pkg;
  localparam int          NCH         = 5;
  localparam int          FRAME_BITS  = 8;
  // frame layout: write flag, register select, data
  localparam int          WR_POS      = 7;
  localparam int          SEL_MSB     = 6;
  localparam int          SEL_LSB     = 5;
  localparam int          DATA_W      = 5;
  // register selects
  localparam logic [1:0]  SEL_DIAG    = 2'h0;
  localparam logic [1:0]  SEL_OUT     = 2'h1;
  localparam logic [1:0]  SEL_HWCFG   = 2'h2;
  localparam logic [1:0]  SEL_SENSE   = 2'h3;
  // hardware_config fields
  localparam int          HW_CTL_POS  = 0;
  localparam int          HW_PWM_POS  = 1;
  localparam int          HW_SBM_POS  = 2;
  localparam int          HW_RST_POS  = 4;
  // sense select: codes at or above NCH disable the sense pin
  localparam logic [2:0]  SENSE_OFF   = 3'h7;
  // reset values
  localparam logic [4:0]  OUT_RST     = 5'h00;
  localparam logic [2:0]  SENSE_RST   = 3'h7;
  localparam logic        PWM_RST     = 1'b0;
  localparam logic        RST_RST     = 1'b0;
  // sclk edge index (from 0) that carries the flag clear: the second edge
  localparam logic [2:0]  CLR_EDGE    = 3'h1;
  localparam logic [2:0]  LAST_EDGE   = 3'h7;

  typedef struct packed {
    logic              wr;
    logic [1:0]        sel;
    logic [DATA_W-1:0] data;
  } dfl_cmd_t;
endpackage
`default_nettype wire

// ==== dfl_top.sv ====
/*
  Channel diagnosis flag logic: error flags, thermal latches, hardware_config,
  sense selection and the serial link that carries diagnosis and commands.
  Assumes the host holds cs low three ref_clk cycles before the first sclk
  edge and high at least six ref_clk cycles between frames.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [R1] error flag is thermal latch OR overload
// [R2] overload flag cleared at second sclk edge
// [R3] thermal fault latches channel off
// [R4] config bit0 one clears thermal latches
// [R5] thermal kept in latch and flag separately
// [R6] flag cleared in frame after clear command
// [R7] first diagnosis after clear still flags fault
// [R8] persistent overload sets flag again at once
// [R9] host selects or disables sense channel
// [R10] bypass result read as config bit2
// [R11] host distrusts overload flags in short PWM
// [R12] bypass compares selected channel drain voltage
// [R13] bypass comparison runs in on and off
// [R14] off channel reads zero error flag
module dfl_top #(
  parameter int NCH = dfl_pkg::NCH
) (
  input  wire logic           ref_clk_i,
  input  wire logic           reset_i,
  input  wire logic           sclk_i,
  input  wire logic           cs_n_i,
  input  wire logic           mosi_i,
  output logic                miso_o,
  output logic                miso_oe_o,
  input  wire logic [NCH-1:0] overload_i,
  input  wire logic [NCH-1:0] thermal_fault_i,
  input  wire logic [NCH-1:0] bypass_cmp_i,
  output logic      [NCH-1:0] gate_on_o,
  output logic      [2:0]     sense_channel_select_o,
  output logic                sense_pin_en_o
);

  // link domain: shift, edge count, event toggles
  logic [2:0]                      bit_cnt_r;
  logic [dfl_pkg::FRAME_BITS-1:0]  rx_sh_r;
  logic                            frame_tgl_r;
  logic                            clr_tgl_r;
  logic                            miso_r;
  logic                            oe_r;
  // values frozen in the ref domain while a frame runs
  logic [dfl_pkg::FRAME_BITS-1:0]  tx_word_r;
  logic                            clr_en_r;

  wire [2:0] out_idx = dfl_pkg::LAST_EDGE - bit_cnt_r;

  // cs high resets the edge count, so a short frame never shifts the next
  always_ff @(posedge sclk_i or posedge cs_n_i or posedge reset_i) begin
    if (cs_n_i || reset_i) begin
      bit_cnt_r <= 3'h0;
      oe_r      <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      oe_r      <= 1'b1;
    end
  end

  // tx_word_r and clr_en_r stand still while cs is low
  always_ff @(posedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_sh_r     <= '0;
      frame_tgl_r <= 1'b0;
      clr_tgl_r   <= 1'b0;
      miso_r      <= 1'b0;
    end else begin
      rx_sh_r <= {rx_sh_r[dfl_pkg::FRAME_BITS-2:0], mosi_i};
      miso_r  <= tx_word_r[out_idx];
      if (bit_cnt_r == dfl_pkg::LAST_EDGE)
        frame_tgl_r <= ~frame_tgl_r;
      if (bit_cnt_r == dfl_pkg::CLR_EDGE && clr_en_r)
        clr_tgl_r <= ~clr_tgl_r;  // [R2]
    end
  end

  assign miso_o    = miso_r;
  assign miso_oe_o = oe_r;

  a_clr_second_edge: assert property (  // [R2]
    @(posedge sclk_i) disable iff (reset_i || cs_n_i)
    (bit_cnt_r == dfl_pkg::CLR_EDGE && clr_en_r) |=> (clr_tgl_r != $past(clr_tgl_r)))
    else $error("flag clear not issued at second sclk edge");

  // ref domain synchronisers
  logic [1:0]     cs_sync_r;
  logic [2:0]     frame_sync_r;
  logic [2:0]     clr_sync_r;
  logic [NCH-1:0] ovl_s1_r, ovl_s2_r;
  logic [NCH-1:0] thf_s1_r, thf_s2_r;
  logic [NCH-1:0] cmp_s1_r, cmp_s2_r;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cs_sync_r    <= 2'h3;
      frame_sync_r <= 3'h0;
      clr_sync_r   <= 3'h0;
      ovl_s1_r     <= '0;
      ovl_s2_r     <= '0;
      thf_s1_r     <= '0;
      thf_s2_r     <= '0;
      cmp_s1_r     <= '0;
      cmp_s2_r     <= '0;
    end else begin
      cs_sync_r    <= {cs_sync_r[0], cs_n_i};
      frame_sync_r <= {frame_sync_r[1:0], frame_tgl_r};
      clr_sync_r   <= {clr_sync_r[1:0], clr_tgl_r};
      ovl_s1_r     <= overload_i;
      ovl_s2_r     <= ovl_s1_r;
      thf_s1_r     <= thermal_fault_i;
      thf_s2_r     <= thf_s1_r;
      cmp_s1_r     <= bypass_cmp_i;
      cmp_s2_r     <= cmp_s1_r;
    end
  end

  wire link_idle = cs_sync_r[1];
  wire frame_ev  = frame_sync_r[2] ^ frame_sync_r[1];
  wire clr_ev    = clr_sync_r[2] ^ clr_sync_r[1];

  // command decode; rx_sh_r is quiet once the frame toggle has been seen
  dfl_pkg::dfl_cmd_t cmd;
  assign cmd = dfl_pkg::dfl_cmd_t'(rx_sh_r);

  wire wr_ev     = frame_ev && cmd.wr;
  wire out_wr    = wr_ev && cmd.sel == dfl_pkg::SEL_OUT;
  wire hw_wr     = wr_ev && cmd.sel == dfl_pkg::SEL_HWCFG;
  wire sense_wr  = wr_ev && cmd.sel == dfl_pkg::SEL_SENSE;
  wire ctl_wr    = hw_wr && cmd.data[dfl_pkg::HW_CTL_POS];  // [R4]

  // registers
  logic [NCH-1:0] on_cmd_r;
  logic [2:0]     sense_sel_r;
  logic           pwm_r;
  logic           rst_bit_r;
  logic [NCH-1:0] therm_r;
  logic [NCH-1:0] err_r;
  logic [1:0]     resp_sel_r;
  logic           ctl_follow_r;
  logic           sbm_r;
  logic [NCH-1:0] gate_r;
  logic [2:0]     sense_out_r;
  logic           sense_en_r;

  // set wins over clear for both latch stages
  wire [NCH-1:0] therm_nxt = (therm_r & ~{NCH{ctl_wr}}) | thf_s2_r;  // [R3] [R4] [R5]
  wire [NCH-1:0] err_set   = therm_r | ovl_s2_r;  // [R1]
  wire [NCH-1:0] err_nxt   = (err_r & ~{NCH{clr_ev}}) | err_set;  // [R2] [R6] [R8]
  wire [NCH-1:0] err_rep   = err_r & on_cmd_r;  // [R14]

  wire           sel_valid = sense_sel_r < 3'(NCH);
  wire           sbm_nxt   = sel_valid ? cmp_s2_r[sense_sel_r] : 1'b0;  // [R12] [R13]

  wire [4:0] hw_read = {rst_bit_r, 1'b0, sbm_r, pwm_r, 1'b0};  // [R10]

  logic [7:0] resp_word;
  always_comb begin
    unique case (resp_sel_r)
      dfl_pkg::SEL_DIAG:  resp_word = 8'(err_rep);
      dfl_pkg::SEL_OUT:   resp_word = 8'(on_cmd_r);
      dfl_pkg::SEL_HWCFG: resp_word = 8'(hw_read);
      dfl_pkg::SEL_SENSE: resp_word = 8'(sense_sel_r);
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      on_cmd_r    <= dfl_pkg::OUT_RST;
      sense_sel_r <= dfl_pkg::SENSE_RST;
      pwm_r       <= dfl_pkg::PWM_RST;
      rst_bit_r   <= dfl_pkg::RST_RST;
    end else begin
      if (out_wr)
        on_cmd_r <= cmd.data[NCH-1:0];
      if (sense_wr)
        sense_sel_r <= cmd.data[2:0];  // [R9]
      if (hw_wr) begin
        pwm_r     <= cmd.data[dfl_pkg::HW_PWM_POS];
        rst_bit_r <= cmd.data[dfl_pkg::HW_RST_POS];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      therm_r      <= '0;
      err_r        <= '0;
      resp_sel_r   <= dfl_pkg::SEL_DIAG;
      ctl_follow_r <= 1'b0;
      sbm_r        <= 1'b0;
    end else begin
      therm_r <= therm_nxt;
      err_r   <= err_nxt;
      sbm_r   <= sbm_nxt;
      if (frame_ev) begin
        resp_sel_r   <= cmd.wr ? dfl_pkg::SEL_DIAG : cmd.sel;
        ctl_follow_r <= ctl_wr;  // [R6]
      end
    end
  end

  // the word is frozen before the clear lands, so the first diagnosis
  // after a clear command still shows the old thermal fault
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_word_r <= '0;
      clr_en_r  <= 1'b0;
    end else if (link_idle) begin
      tx_word_r <= resp_word;  // [R7]
      clr_en_r  <= (resp_sel_r == dfl_pkg::SEL_DIAG) || ctl_follow_r;  // [R2] [R6]
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gate_r      <= '0;
      sense_out_r <= dfl_pkg::SENSE_OFF;
      sense_en_r  <= 1'b0;
    end else begin
      gate_r      <= on_cmd_r & ~therm_r;  // [R3]
      sense_out_r <= sense_sel_r;
      sense_en_r  <= sel_valid;  // [R9]
    end
  end

  assign gate_on_o              = gate_r;
  assign sense_channel_select_o = sense_out_r;
  assign sense_pin_en_o         = sense_en_r;

  a_therm_gate_off: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // [R3]
    (|therm_r) |=> ((gate_on_o & $past(therm_r)) == '0))
    else $error("latched channel still driven on");

  a_ctl_clears_all: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // [R4]
    (ctl_wr && thf_s2_r == '0) |=> (therm_r == '0))
    else $error("clear command left a thermal latch set");

  a_ctl_zero_keeps: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // [R4]
    (hw_wr && !cmd.data[dfl_pkg::HW_CTL_POS]) |=> (($past(therm_r) & ~therm_r) == '0))
    else $error("thermal latch lost without clear command");

  a_err_or_sets: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // [R1]
    (|err_set) |=> ((err_r & $past(err_set)) == $past(err_set)))
    else $error("error flag missed thermal or overload");

  a_err_clear_value: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // [R2]
    clr_ev |=> (err_r == $past(err_set)))
    else $error("error flag clear gave wrong value");

  a_err_holds: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // [R5]
    !clr_ev |=> (($past(err_r) & ~err_r) == '0))
    else $error("error flag dropped without clear");

  a_ovl_resets: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // [R8]
    (clr_ev && (|ovl_s2_r)) |=> ((err_r & $past(ovl_s2_r)) == $past(ovl_s2_r)))
    else $error("persistent overload not set again");

  a_sbm_selected: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // [R12]
    sel_valid |=> (sbm_r == $past(cmp_s2_r[sense_sel_r])))
    else $error("bypass result not from selected channel");

  a_sense_disable: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // [R9]
    (!sel_valid) [*2] |-> !sense_pin_en_o)
    else $error("sense pin enabled while disabled");

  a_ctl_next_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // [R6]
    (ctl_wr && link_idle) |-> ##[1:3] clr_en_r)
    else $error("frame after clear command does not clear flag");

  a_off_reads_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)  // [R14]
    (link_idle && resp_sel_r == dfl_pkg::SEL_DIAG) |=>
      ((tx_word_r[NCH-1:0] & ~$past(on_cmd_r)) == '0))
    else $error("off channel reports an error flag");

endmodule
`default_nettype wire

// ==== dfl_host.sv ====
/*
  Host model for the diagnosis link: sends one byte per frame, MSB first,
  and collects the byte the device shifts back.
  Assumes the device samples on rising sclk and that ref_clk runs at 50 MHz.
*/
`timescale 1ns/1ps
`default_nettype none
module dfl_host (
  input  wire logic ref_clk_i,
  input  wire logic miso_i,
  input  wire logic miso_oe_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  logic rx_last = 1'b0;
  initial begin
    sclk_o = 1'b0;
    // non-blocking, so the device sees a rising cs once its processes wait
    cs_n_o <= 1'b1;
    mosi_o = 1'b0;
  end
  // sclk stands still between frames; gaps exceed the setup and idle spans
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    @(posedge ref_clk_i);
    #1 cs_n_o = 1'b0;
    #75;
    for (int i = 7; i >= 0; i--) begin
      mosi_o = tx[i];
      #3 sclk_o = 1'b1;
      #3 sclk_o = 1'b0;
      // a released line reads as the inverse of its last level
      rx_last = miso_oe_i ? miso_i : ~rx_last;
      rx[i] = rx_last;
    end
    #3 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #130;
  endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
/*
  Self-checking bench for the diagnosis flag block.
  Assumes the host model keeps frame spacing; fault inputs are steady levels.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int N = dfl_pkg::NCH;
  logic         clk = 1'b0;
  logic         rst;
  logic         sclk, cs_n, mosi, miso, miso_oe, sen;
  logic [N-1:0] ovl = '0;
  logic [N-1:0] thm = '0;
  logic [N-1:0] byp = '0;
  logic [N-1:0] gate, on;
  logic [2:0]   ssel;
  logic [7:0]   rx;
  int           fails = 0;
  int           n_checks = 0;
  always #10 clk = ~clk;
  dfl_top #(.NCH(N)) dfl_top_inst (.ref_clk_i(clk), .reset_i(rst), .sclk_i(sclk),
    .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .overload_i(ovl),
    .thermal_fault_i(thm), .bypass_cmp_i(byp), .gate_on_o(gate),
    .sense_channel_select_o(ssel), .sense_pin_en_o(sen));
  dfl_host dfl_host_inst (.ref_clk_i(clk), .miso_i(miso), .miso_oe_i(miso_oe),
    .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] diag_w(input logic [N-1:0] f, input logic [N-1:0] o);
    return {3'h0, f & o};
  endfunction
  function automatic logic [7:0] hw_w(input logic r, input logic b, input logic p);
    return {3'h0, r, 1'b0, b, p, 1'b0};
  endfunction
  task automatic fr(input logic [7:0] tx);
    dfl_host_inst.xfer(tx, rx);
  endtask
  task automatic pulse(input logic [N-1:0] o, input logic [N-1:0] t, input int hold);
    @(posedge clk);
    ovl <= o;
    thm <= t;
    repeat (4) @(posedge clk);
    if (hold == 0) begin
      ovl <= '0;
      thm <= '0;
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic finish_test;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    // raised by non-blocking assignment so the link-side registers see an edge
    rst <= 1'b1;
    void'($urandom(32'hd8261237));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #2;
    chk({gate, ssel}, 8'h07);
    chk({6'h0, sen, miso_oe}, 8'h00);
    for (int c = 0; c < 8; c++) begin
      fr({3'b111, 5'(c)});
      chk({4'h0, sen, ssel}, {4'h0, (c < N) ? 1'b1 : 1'b0, 3'(c)});
    end
    on = N'($urandom) | N'(1);
    on[1] = 1'b0;
    fr({3'b101, on});
    chk({3'h0, gate}, {3'h0, on});
    // outputs stay steady: no short off-time, so every overload flag is genuine
    pulse(N'(3), '0, 0);
    fr(8'h00);
    chk(rx, diag_w(N'(3), on));
    fr(8'h00);
    chk(rx, 8'h00);
    pulse(N'(1), '0, 1);
    fr(8'h00);
    fr(8'h00);
    chk(rx, diag_w(N'(1), on));
    pulse('0, '0, 0);
    fr(8'h00);
    fr(8'h00);
    chk(rx, 8'h00);
    pulse('0, N'(1), 0);
    chk({3'h0, gate}, {3'h0, on & ~N'(1)});
    fr(8'h00);
    fr(8'h00);
    chk(rx, diag_w(N'(1), on));
    fr(8'hc0);
    chk({3'h0, gate}, {3'h0, on & ~N'(1)});
    fr(8'hc1);
    chk({3'h0, gate}, {3'h0, on});
    fr(8'h00);
    chk(rx, diag_w(N'(1), on));
    fr(8'h00);
    chk(rx, 8'h00);
    fr(8'hd2);
    for (int c = 0; c < N; c++) begin
      @(posedge clk);
      byp <= N'($urandom);
      fr({3'b111, 5'(c)});
      fr(8'h40);
      fr(8'h00);
      chk(rx, hw_w(1'b1, byp[c], 1'b1));
    end
    finish_test();
  end
  // about forty frames of 260 ns each; the limit leaves a wide margin
  initial begin
    #200000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
